/* File: hw/tws_pkg.sv */
// Shared constants and carrier types for the three-wire serial EEPROM port
package tws_pkg;

  // Array geometry: 128 bytes, seen as 64 x 16 or 128 x 8
  localparam int BYTE_AW = 7;
  localparam int NUM_BYTES = 128;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;

  // Serial field lengths
  localparam logic [4:0] OPC_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST_X16 = 5'h05;
  localparam logic [4:0] ADDR_LAST_X8 = 5'h06;
  localparam logic [4:0] DATA_LAST_X16 = 5'h0F;
  localparam logic [4:0] DATA_LAST_X8 = 5'h07;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Operation codes and sub-codes carried in the top address bits
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;

  // Values after reset and erased pattern
  localparam logic LOCK_RST = 1'h1;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Self-timed programming time
  localparam int T_WRITE_MS = 5;
  localparam int CLK_HZ = 50000000;
  localparam int WRITE_CYCLES = T_WRITE_MS * (CLK_HZ / 1000);
  localparam int WAIT_W = 18;

  typedef struct packed {
    logic select;
    logic shift_clock_in;
    logic serial_in;
    logic width_strap;
  } tws_pins_type;

  typedef struct packed {
    logic fill;
    logic wide;
    logic [6:0] addr;
    logic [15:0] data;
  } tws_prog_type;

endpackage

/* File: hw/tws_mem.sv */
// Byte-wide array with one write port and a registered read port
`timescale 1ns/10ps
module tws_mem (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [6:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [6:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_q [tws_pkg::NUM_BYTES];

  // Delivered blank
  initial begin
    for (int i = 0; i < tws_pkg::NUM_BYTES; i++) begin
      mem_q[i] = tws_pkg::ERASED_BYTE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule // tws_mem

/* File: hw/tws_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tws_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;

  assign o_in_ready = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
  assign o_out_valid = (wr_q != rd_q);
  assign o_out_data = buf_q[rd_q[PW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      buf_q[wr_q[PW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // tws_fifo

/* File: hw/tws_eeprom_port.sv */
// Three-wire serial EEPROM port: command decoder, read streamer, programming engine
//
// Operation
// RQ1 - Sample serial input on shift clock rise
// RQ2 - Read bits change on shift clock rise
// RQ3 - Show ready/busy after write until start bit
// RQ4 - Output floats whenever select is low
// RQ5 - Host drops select after every command
// RQ6 - Strap high or open: 16-bit words
// RQ7 - Strap grounded: 8-bit words
// RQ8 - Host sends start, opcode, address, data
// RQ9 - Command begins at first one after select
// RQ10 - Read: zero dummy bit, then word MSB-first
// RQ11 - Held select keeps reading following words
// RQ12 - Writes locked from reset until unlock command
// RQ13 - Busy low while programming, high when done
`timescale 1ns/10ps
module tws_eeprom_port #(
  parameter int P_WRITE_CYCLES = tws_pkg::WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_select,
  input wire logic i_shift_clock_in,
  input wire logic i_serial_in,
  input wire logic i_width_strap,
  output logic o_serial_out,
  output logic o_serial_out_oe_n
);
  typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_DATA, S_READ, S_DONE} tws_ser_type;
  typedef enum logic [1:0] {E_IDLE, E_PROG, E_WAIT} tws_eng_type;

  tws_pkg::tws_pins_type pins_in;
  tws_pkg::tws_pins_type pins_s1_q;
  tws_pkg::tws_pins_type pins_s2_q;
  logic sk_prev_q;
  logic sk_rise;
  logic sel;
  logic din;

  tws_ser_type state_q;
  logic [4:0] cnt_q;
  logic [1:0] opc_q;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic [15:0] wdata_q;
  logic [15:0] wdata_d;
  logic wide_q;
  logic lock_q;
  logic status_q;
  logic addr_last;
  logic data_last;
  logic [1:0] sub;

  logic [6:0] raddr_q;
  logic rd_req_q;
  logic ld1_q;
  logic ld2_q;
  logic [7:0] sh_q;
  logic [2:0] bitc_q;
  logic [7:0] rdata;

  tws_pkg::tws_prog_type push_q;
  logic push_valid_q;
  logic fifo_ready;
  logic fifo_valid;
  logic pop;
  tws_pkg::tws_prog_type head;

  tws_eng_type eng_q;
  tws_pkg::tws_prog_type job_q;
  logic [6:0] eaddr_q;
  logic [tws_pkg::WAIT_W-1:0] wait_q;
  logic we;
  logic [7:0] wbyte;
  logic prog_last;
  logic busy;

  // Pin synchronisers
  assign pins_in = '{select: i_select, shift_clock_in: i_shift_clock_in,
                     serial_in: i_serial_in, width_strap: i_width_strap};

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
      sk_prev_q <= 1'b0;
    end else begin
      pins_s1_q <= pins_in;
      pins_s2_q <= pins_s1_q;
      sk_prev_q <= pins_s2_q.shift_clock_in;
    end
  end

  assign sel = pins_s2_q.select;
  assign din = pins_s2_q.serial_in;
  assign sk_rise = sel && pins_s2_q.shift_clock_in && !sk_prev_q; // [RQ1]

  assign addr_d = {addr_q[5:0], din};
  assign wdata_d = {wdata_q[14:0], din};
  assign addr_last = (cnt_q == (wide_q ? tws_pkg::ADDR_LAST_X16 : tws_pkg::ADDR_LAST_X8));
  assign data_last = (cnt_q == (wide_q ? tws_pkg::DATA_LAST_X16 : tws_pkg::DATA_LAST_X8));
  assign sub = wide_q ? addr_d[5:4] : addr_d[6:5];
  assign busy = (eng_q != E_IDLE) || fifo_valid;

  // Word width follows the strap, taken only between commands
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wide_q <= 1'b1;
    end else if (!sel) begin
      wide_q <= pins_s2_q.width_strap; // [RQ6] [RQ7]
    end
  end

  // Command decoder
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      opc_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
    end else if (!sel) begin
      state_q <= S_IDLE;
    end else if (sk_rise) begin
      case (state_q)
        S_IDLE: begin
          if (din) begin
            state_q <= S_OPC; // [RQ9]
            cnt_q <= '0;
          end
        end
        S_OPC: begin
          opc_q <= {opc_q[0], din};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == tws_pkg::OPC_LAST) begin
            state_q <= S_ADDR;
            cnt_q <= '0;
          end
        end
        S_ADDR: begin
          addr_q <= addr_d;
          cnt_q <= cnt_q + 5'h01;
          if (addr_last) begin
            cnt_q <= '0;
            if (opc_q == tws_pkg::OPC_READ) begin
              state_q <= S_READ;
            end else if (opc_q == tws_pkg::OPC_WRITE ||
                         (opc_q == tws_pkg::OPC_EXT && sub == tws_pkg::SUB_FILL)) begin
              state_q <= S_DATA;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_DATA: begin
          wdata_q <= wdata_d;
          cnt_q <= cnt_q + 5'h01;
          if (data_last) begin
            state_q <= S_DONE;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Write lock: set from reset and by the lock command
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      lock_q <= tws_pkg::LOCK_RST; // [RQ12]
    end else if (sk_rise && state_q == S_ADDR && addr_last && opc_q == tws_pkg::OPC_EXT) begin
      if (sub == tws_pkg::SUB_UNLOCK) begin
        lock_q <= 1'b0; // [RQ12]
      end else if (sub == tws_pkg::SUB_LOCK) begin
        lock_q <= 1'b1;
      end
    end
  end

  // Queue programming jobs; refused while locked or queue full
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      push_valid_q <= 1'b0;
      push_q <= '0;
    end else begin
      push_valid_q <= 1'b0;
      if (sk_rise && !lock_q && fifo_ready && !push_valid_q) begin
        if (state_q == S_DATA && data_last) begin
          push_valid_q <= 1'b1;
          push_q <= '{fill: (opc_q == tws_pkg::OPC_EXT), wide: wide_q,
                      addr: wide_q ? {addr_q[5:0], 1'b0} : addr_q,
                      data: wide_q ? wdata_d : {8'h00, wdata_d[7:0]}};
        end else if (state_q == S_ADDR && addr_last &&
                     (opc_q == tws_pkg::OPC_ERASE ||
                      (opc_q == tws_pkg::OPC_EXT && sub == tws_pkg::SUB_CLEAR))) begin
          push_valid_q <= 1'b1;
          push_q <= '{fill: (opc_q == tws_pkg::OPC_EXT), wide: wide_q,
                      addr: wide_q ? {addr_d[5:0], 1'b0} : addr_d,
                      data: tws_pkg::ERASED_WORD};
        end
      end
    end
  end

  // Status pending after an accepted write-type command
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      status_q <= 1'b0;
    end else if (push_valid_q) begin
      status_q <= 1'b1; // [RQ3]
    end else if (sk_rise && state_q == S_IDLE && din) begin
      status_q <= 1'b0; // [RQ3]
    end
  end

  // Read address and byte prefetch
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      raddr_q <= '0;
      rd_req_q <= 1'b0;
      ld1_q <= 1'b0;
      ld2_q <= 1'b0;
      sh_q <= '0;
      bitc_q <= '0;
    end else begin
      rd_req_q <= 1'b0;
      ld1_q <= rd_req_q;
      ld2_q <= ld1_q;
      if (sk_rise && state_q == S_ADDR && addr_last && opc_q == tws_pkg::OPC_READ) begin
        raddr_q <= wide_q ? {addr_d[5:0], 1'b0} : addr_d;
        rd_req_q <= 1'b1;
        bitc_q <= '0;
      end else if (sk_rise && state_q == S_READ) begin
        sh_q <= {sh_q[6:0], 1'b0};
        bitc_q <= bitc_q + 3'h1;
        if (bitc_q == tws_pkg::BIT_LAST) begin
          raddr_q <= raddr_q + 7'h01; // [RQ11]
          rd_req_q <= 1'b1;
        end
      end else if (ld2_q) begin
        sh_q <= rdata;
      end
    end
  end

  // Serial output and its enable
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_serial_out <= 1'b1;
      o_serial_out_oe_n <= 1'b1;
    end else if (!sel) begin
      o_serial_out <= 1'b1;
      o_serial_out_oe_n <= 1'b1; // [RQ4]
    end else if (state_q == S_IDLE && status_q && !(sk_rise && din)) begin
      o_serial_out <= !busy; // [RQ3] [RQ13]
      o_serial_out_oe_n <= 1'b0;
    end else if (sk_rise && state_q == S_ADDR && addr_last && opc_q == tws_pkg::OPC_READ) begin
      o_serial_out <= 1'b0; // [RQ10]
      o_serial_out_oe_n <= 1'b0;
    end else if (sk_rise && state_q == S_READ) begin
      o_serial_out <= sh_q[7]; // [RQ2] [RQ10]
      o_serial_out_oe_n <= 1'b0;
    end else if (state_q != S_READ) begin
      o_serial_out <= 1'b1;
      o_serial_out_oe_n <= 1'b1;
    end
  end

  // Programming engine
  assign pop = (eng_q == E_IDLE) && fifo_valid;
  assign prog_last = job_q.fill ? (eaddr_q == 7'h7F) :
                     (!job_q.wide || eaddr_q[0]);
  assign we = (eng_q == E_PROG);
  assign wbyte = (job_q.wide && !eaddr_q[0]) ? job_q.data[15:8] : job_q.data[7:0];

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      eng_q <= E_IDLE;
      job_q <= '0;
      eaddr_q <= '0;
      wait_q <= '0;
    end else begin
      case (eng_q)
        E_IDLE: begin
          if (fifo_valid) begin
            job_q <= head;
            eaddr_q <= head.fill ? 7'h00 : head.addr;
            eng_q <= E_PROG;
          end
        end
        E_PROG: begin
          eaddr_q <= eaddr_q + 7'h01;
          if (prog_last) begin
            wait_q <= tws_pkg::WAIT_W'(P_WRITE_CYCLES - 1);
            eng_q <= E_WAIT;
          end
        end
        E_WAIT: begin
          wait_q <= wait_q - 1'b1; // [RQ13]
          if (wait_q == '0) begin
            eng_q <= E_IDLE;
          end
        end
        default: begin
          eng_q <= E_IDLE;
        end
      endcase
    end
  end

  tws_fifo #(
    .WIDTH($bits(tws_pkg::tws_prog_type)),
    .DEPTH(tws_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(push_valid_q),
    .o_in_ready(fifo_ready),
    .i_in_data(push_q),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop),
    .o_out_data(head)
  );

  tws_mem u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(we),
    .i_waddr(eaddr_q),
    .i_wdata(wbyte),
    .i_raddr(raddr_q),
    .o_rdata(rdata)
  );
endmodule // tws_eeprom_port

/* File: tb/tws_eeprom_port_sva.sv */
// Port checker for the serial EEPROM port
`timescale 1ns/10ps
module tws_eeprom_port_sva #(
  parameter int P_WRITE_CYCLES = 250000
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_select,
  input wire logic i_shift_clock_in,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe_n
);
  localparam int BUSY_MAX = 17 * (140 + P_WRITE_CYCLES);
  logic [31:0] busy_cnt_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence sck_quiet_s;
    $stable(i_shift_clock_in)[*6];
  endsequence
  sequence sel_held_s;
    i_select[*8];
  endsequence
  sequence sel_gone_s;
    !i_select[*6];
  endsequence
  // Pin rise seen three samples back, through the input synchroniser
  sequence sck_rose_s;
    $past(i_shift_clock_in, 3) && !$past(i_shift_clock_in, 4);
  endsequence
  // Length of an unbroken driven low level
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      busy_cnt_q <= '0;
    end else if (i_select && !o_serial_out_oe_n && !o_serial_out) begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end else begin
      busy_cnt_q <= '0;
    end
  end
  reset_idle_a: assert property ($fell(i_reset) |-> o_serial_out_oe_n && o_serial_out)
    else $error("outputs not idle after reset");
  hiz_idle_a: assert property (sel_gone_s |-> o_serial_out_oe_n)
    else $error("output driven while deselected");
  idle_level_a: assert property (o_serial_out_oe_n |-> o_serial_out)
    else $error("released output not high");
  release_time_a: assert property ($fell(i_select) |-> ##[1:6] o_serial_out_oe_n)
    else $error("output not released after deselect");
  drive_cause_a: assert property (!o_serial_out_oe_n |->
    $past(i_select, 3) || $past(i_select, 4) || $past(i_select, 5))
    else $error("output driven without select");
  read_step_a: assert property (sck_quiet_s ##0 (!o_serial_out_oe_n &&
    !$past(o_serial_out_oe_n)) |-> !$fell(o_serial_out))
    else $error("read bit changed without shift clock rise");
  read_edge_a: assert property (!o_serial_out_oe_n && !$past(o_serial_out_oe_n) &&
    $fell(o_serial_out) |-> sck_rose_s)
    else $error("read bit fell without shift clock rise");
  status_hold_a: assert property ((sck_quiet_s and sel_held_s) |->
    $stable(o_serial_out_oe_n))
    else $error("status drive changed while selected");
  busy_bound_a: assert property (busy_cnt_q < BUSY_MAX)
    else $error("busy level held too long");
endmodule // tws_eeprom_port_sva

bind tws_eeprom_port tws_eeprom_port_sva #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) i_sva (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_select(i_select),
  .i_shift_clock_in(i_shift_clock_in), .o_serial_out(o_serial_out),
  .o_serial_out_oe_n(o_serial_out_oe_n));

/* File: tb/tws_host.sv */
// Host model: drives select, shift clock and serial data
`timescale 1ns/10ps
module tws_host (
  input wire logic i_clk_sys,
  input wire logic i_dio,
  output logic o_select,
  output logic o_sck,
  output logic o_sdi
);
  initial begin
    o_select = 1'b0;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Select dropped between commands
  task automatic sel(input logic v);
    o_select = v;
    hw(12);
  endtask
  // MSB first; output is captured just before each rise
  task automatic shift(input logic [47:0] b, input int n, output logic [47:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi = b[i];
      hw(4);
      q = {q[46:0], i_dio};
      o_sck = 1'b1;
      hw(4);
      o_sck = 1'b0;
    end
    o_sdi = ~o_sdi;
  endtask
endmodule // tws_host

/* File: tb/tws_eeprom_port_tb.sv */
// Self-checking bench for the serial EEPROM port
`timescale 1ns/10ps
module tws_eeprom_port_tb;
  localparam int P_WC = 200;
  logic clk;
  logic rst;
  logic strap;
  logic sel, sck, sdi, so, oe_n;
  wire dio;
  logic [31:0] seed = 32'h54;
  logic [7:0] mem [128];
  logic [47:0] q;
  logic [15:0] d;
  logic [6:0] a;
  int fails = 0;
  int cmp_count = 0;
  assign dio = oe_n ? 1'bz : so;
  tws_host u_host (.i_clk_sys(clk), .i_dio(dio), .o_select(sel), .o_sck(sck), .o_sdi(sdi));
  tws_eeprom_port #(.P_WRITE_CYCLES(P_WC)) i_dut (.i_clk_sys(clk), .i_reset(rst),
    .i_select(sel), .i_shift_clock_in(sck), .i_serial_in(sdi), .i_width_strap(strap),
    .o_serial_out(so), .o_serial_out_oe_n(oe_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] sub(input logic [1:0] s);
    return strap ? {1'b0, s, 4'h0} : {s, 5'h0};
  endfunction
  function automatic logic [32:0] exp_rd(input logic [6:0] ea);
    logic [6:0] b0;
    b0 = strap ? {ea[5:0], 1'b0} : ea;
    if (strap) return {1'b0, mem[b0], mem[7'(b0 + 1)], mem[7'(b0 + 2)], mem[7'(b0 + 3)]};
    return {17'h0, mem[b0], mem[7'(b0 + 1)]};
  endfunction
  task automatic conclude();
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] op, input logic [6:0] ca, input int z, input int tl,
      input logic [31:0] tv);
    logic [47:0] b;
    int al;
    al = strap ? 6 : 7;
    b = {45'h0, 1'b1, op};
    b = (b << al) | 48'(strap ? ca[5:0] : ca);
    b = (b << tl) | (48'(tv) & ((48'h1 << tl) - 48'h1));
    u_host.sel(1'b1);
    u_host.shift(b, 3 + al + tl + z, q);
    u_host.sel(1'b0);
  endtask
  task automatic rd(input logic [6:0] ra);
    int m;
    m = strap ? 32 : 16;
    cmd(tws_pkg::OPC_READ, ra, 2'(rnd()), m + 1, 32'h0);
    chk(q[32:0] & ((33'h1 << (m + 1)) - 33'h1), exp_rd(ra));
  endtask
  task automatic stat();
    int i;
    u_host.sel(1'b1);
    chk({oe_n, dio}, 2'h0);
    for (i = 0; i < 4000 && dio !== 1'b1; i++) @(negedge clk);
    chk(dio, 1'b1);
    if (i == 4000) conclude();
    u_host.sel(1'b0);
    chk(oe_n, 1'b1);
  endtask
  task automatic put(input logic [6:0] pa, input logic [15:0] pv);
    if (strap) begin
      mem[{pa[5:0], 1'b0}] = pv[15:8];
      mem[{pa[5:0], 1'b1}] = pv[7:0];
    end else begin
      mem[pa] = pv[7:0];
    end
  endtask
  task automatic locked(input logic [6:0] la);
    cmd(tws_pkg::OPC_WRITE, la, 0, strap ? 16 : 8, rnd());
    u_host.sel(1'b1);
    chk(oe_n, 1'b1);
    u_host.sel(1'b0);
    rd(la);
  endtask
  initial begin
    rst = 1'b1;
    strap = 1'b1;
    for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk({oe_n, so}, 2'h3);
    locked(7'h05);
    for (int w = 1; w >= 0; w--) begin
      strap = w[0];
      // Strap settles while deselected
      repeat (4) @(negedge clk);
      cmd(tws_pkg::OPC_EXT, sub(tws_pkg::SUB_UNLOCK), 0, 0, 32'h0);
      for (int k = 0; k < 3; k++) begin
        a = (k == 0) ? 7'h7F : 7'(rnd());
        d = 16'(rnd());
        cmd(tws_pkg::OPC_WRITE, a, 2'(rnd()), strap ? 16 : 8, 32'(d));
        put(a, d);
        stat();
        rd(a);
      end
    end
    d = 16'(rnd());
    cmd(tws_pkg::OPC_EXT, sub(tws_pkg::SUB_FILL), 0, 8, 32'(d));
    for (int i = 0; i < 128; i++) mem[i] = d[7:0];
    stat();
    rd(7'(rnd()));
    a = 7'(rnd());
    cmd(tws_pkg::OPC_ERASE, a, 0, 0, 32'h0);
    put(a, 16'hFFFF);
    stat();
    rd(a);
    cmd(tws_pkg::OPC_EXT, sub(tws_pkg::SUB_CLEAR), 0, 0, 32'h0);
    for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
    stat();
    rd(7'(rnd()));
    cmd(tws_pkg::OPC_EXT, sub(tws_pkg::SUB_LOCK), 0, 0, 32'h0);
    locked(a);
    // Reset in mid-run locks writes again, array kept
    cmd(tws_pkg::OPC_EXT, sub(tws_pkg::SUB_UNLOCK), 0, 0, 32'h0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk({oe_n, so}, 2'h3);
    locked(7'(rnd()));
    conclude();
  end
endmodule // tws_eeprom_port_tb
